/* File: hw/pcwc_pkg.sv */
// Package: constants for the PLL calibration wait control block
package pcwc_pkg;
  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] PCWC_OFS_WAIT_TIMES = 8'h77;
  localparam logic [7:0] PCWC_OFS_LOOP_BW    = 8'h78;
  localparam int         PCWC_CLW_LSB        = 2;
  localparam int         PCWC_VCO_LSB        = 0;
  localparam int         PCWC_NBW_BIT        = 0;
  localparam logic [1:0] PCWC_CLW_RESET      = 2'h0;
  localparam logic [1:0] PCWC_VCO_RESET      = 2'h1;
  localparam logic       PCWC_NBW_RESET      = 1'b0;
  // ----------------------------------------
  // Timing, in microseconds and clock cycles, clock rate and counter width
  // ----------------------------------------
  localparam int unsigned PCWC_CLK_MHZ   = 50;
  localparam int unsigned PCWC_CLW0_US   = 30;
  localparam int unsigned PCWC_CLW1_US   = 300;
  localparam int unsigned PCWC_CLW2_US   = 30000;
  localparam int unsigned PCWC_CLW3_US   = 300000;
  localparam int unsigned PCWC_VCO0_US   = 20;
  localparam int unsigned PCWC_VCO1_US   = 400;
  localparam int unsigned PCWC_VCO2_US   = 8000;
  localparam int unsigned PCWC_VCO3_US   = 200000;
  localparam int unsigned PCWC_CLW0_CYC  = PCWC_CLW0_US * PCWC_CLK_MHZ;
  localparam int unsigned PCWC_VCO0_CYC  = PCWC_VCO0_US * PCWC_CLK_MHZ;
  localparam int          PCWC_CNT_W     = 24;
  // ----------------------------------------
  // Calibration sequence
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCWC_IDLE = 2'b00,
    PCWC_VCO  = 2'b01,
    PCWC_CLSD = 2'b11,
    PCWC_DONE = 2'b10
  } pcwc_state_type;
endpackage

/* File: hw/pcwc_timer.sv */
// Down counter timing one wait period in always-on clock cycles
`timescale 1ns/100ps
module pcwc_timer
  import pcwc_pkg::*;
#(
  parameter int CNT_W = PCWC_CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  expire_q
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             run_q;
  logic             last;

  assign last  = run_q && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
  assign cnt_d = load ? cycles : (run_q ? cnt_q - 1'b1 : cnt_q);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      run_q    <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      run_q    <= load || (run_q && !last);
      expire_q <= last && !load;
    end
  end
endmodule

/* File: hw/pcwc_top.sv */
// PLL calibration wait timing and loop bandwidth select
`timescale 1ns/100ps
module pcwc_top
  import pcwc_pkg::*;
#(
  parameter int unsigned CLW1_CYC = PCWC_CLW1_US * PCWC_CLK_MHZ,
  parameter int unsigned CLW2_CYC = PCWC_CLW2_US * PCWC_CLK_MHZ,
  parameter int unsigned CLW3_CYC = PCWC_CLW3_US * PCWC_CLK_MHZ,
  parameter int unsigned VCO1_CYC = PCWC_VCO1_US * PCWC_CLK_MHZ,
  parameter int unsigned VCO2_CYC = PCWC_VCO2_US * PCWC_CLK_MHZ,
  parameter int unsigned VCO3_CYC = PCWC_VCO3_US * PCWC_CLK_MHZ
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  input  wire logic       eep_load,
  input  wire logic [7:0] eep_wait_times,
  input  wire logic [7:0] eep_loop_bw,
  input  wire logic       cal_start,
  output logic            cal_busy_q,
  output logic            vco_settle_wait_q,
  output logic            closed_loop_wait_q,
  output logic            cal_done_q,
  output logic            narrow_loop_bw_sel_q
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [1:0] closed_loop_wait_sel_q;
  logic [1:0] vco_settle_wait_sel_q;
  logic       wr_wait;
  logic       wr_bw;
  logic       rd_wait;
  logic       rd_bw;
  logic [7:0] rdata_d;

  assign wr_wait = reg_wr && (reg_addr == PCWC_OFS_WAIT_TIMES);
  assign wr_bw   = reg_wr && (reg_addr == PCWC_OFS_LOOP_BW);
  assign rd_wait = reg_addr == PCWC_OFS_WAIT_TIMES;
  assign rd_bw   = reg_addr == PCWC_OFS_LOOP_BW;
  assign rdata_d = rd_wait ? {4'h0, closed_loop_wait_sel_q, vco_settle_wait_sel_q} :
                   rd_bw   ? {7'h00, narrow_loop_bw_sel_q} : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      closed_loop_wait_sel_q <= PCWC_CLW_RESET;
      vco_settle_wait_sel_q  <= PCWC_VCO_RESET;
      narrow_loop_bw_sel_q   <= PCWC_NBW_RESET;
      reg_rdata_q            <= 8'h00;
    end else begin
      if (wr_wait) begin
        closed_loop_wait_sel_q <= reg_wdata[PCWC_CLW_LSB +: 2];
        vco_settle_wait_sel_q  <= reg_wdata[PCWC_VCO_LSB +: 2];
      end else if (eep_load) begin
        closed_loop_wait_sel_q <= eep_wait_times[PCWC_CLW_LSB +: 2];
        vco_settle_wait_sel_q  <= eep_wait_times[PCWC_VCO_LSB +: 2];
      end
      if (wr_bw) begin
        narrow_loop_bw_sel_q <= reg_wdata[PCWC_NBW_BIT];
      end else if (eep_load) begin
        narrow_loop_bw_sel_q <= eep_loop_bw[PCWC_NBW_BIT];
      end
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // Wait period decode
  // ----------------------------------------
  logic [1:0]            clw_code_q;
  logic [PCWC_CNT_W-1:0] vco_cycles;
  logic [PCWC_CNT_W-1:0] clw_cycles;

  assign vco_cycles = (vco_settle_wait_sel_q == 2'h0) ? PCWC_CNT_W'(PCWC_VCO0_CYC) :
                      (vco_settle_wait_sel_q == 2'h1) ? PCWC_CNT_W'(VCO1_CYC) :
                      (vco_settle_wait_sel_q == 2'h2) ? PCWC_CNT_W'(VCO2_CYC) :
                                                        PCWC_CNT_W'(VCO3_CYC);
  assign clw_cycles = (clw_code_q == 2'h0) ? PCWC_CNT_W'(PCWC_CLW0_CYC) :
                      (clw_code_q == 2'h1) ? PCWC_CNT_W'(CLW1_CYC) :
                      (clw_code_q == 2'h2) ? PCWC_CNT_W'(CLW2_CYC) :
                                             PCWC_CNT_W'(CLW3_CYC);

  // ----------------------------------------
  // Calibration sequence
  // ----------------------------------------
  pcwc_state_type state_q;
  pcwc_state_type state_d;
  logic           start_ok;
  logic           tmr_load;
  logic           tmr_expire;
  logic [PCWC_CNT_W-1:0] tmr_cycles;

  assign start_ok   = cal_start && (state_q == PCWC_IDLE);
  assign tmr_load   = start_ok || ((state_q == PCWC_VCO) && tmr_expire);
  assign tmr_cycles = start_ok ? vco_cycles : clw_cycles;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PCWC_IDLE: begin
        if (cal_start) begin
          state_d = PCWC_VCO;
        end
      end
      PCWC_VCO: begin
        if (tmr_expire) begin
          state_d = PCWC_CLSD;
        end
      end
      PCWC_CLSD: begin
        if (tmr_expire) begin
          state_d = PCWC_DONE;
        end
      end
      PCWC_DONE: state_d = PCWC_IDLE;
      default:   state_d = PCWC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q            <= PCWC_IDLE;
      clw_code_q         <= PCWC_CLW_RESET;
      cal_busy_q         <= 1'b0;
      vco_settle_wait_q  <= 1'b0;
      closed_loop_wait_q <= 1'b0;
      cal_done_q         <= 1'b0;
    end else begin
      state_q            <= state_d;
      if (start_ok) begin
        clw_code_q <= closed_loop_wait_sel_q;
      end
      cal_busy_q         <= (state_d == PCWC_VCO) || (state_d == PCWC_CLSD);
      vco_settle_wait_q  <= state_d == PCWC_VCO;
      closed_loop_wait_q <= state_d == PCWC_CLSD;
      cal_done_q         <= state_d == PCWC_DONE;
    end
  end

  pcwc_timer #(
    .CNT_W (PCWC_CNT_W)
  ) u_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .cycles   (tmr_cycles),
    .expire_q (tmr_expire)
  );
endmodule

/* File: verif/pcwc_top_assertions.sv */
// Assertions on the PLL calibration wait control ports
`timescale 1ns/100ps
module pcwc_top_checker
  import pcwc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       eep_load,
  input wire logic [7:0] eep_wait_times,
  input wire logic [7:0] eep_loop_bw,
  input wire logic       cal_start,
  input wire logic       cal_busy_q,
  input wire logic       vco_settle_wait_q,
  input wire logic       closed_loop_wait_q,
  input wire logic       cal_done_q,
  input wire logic       narrow_loop_bw_sel_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_start_vco_wait: assert property (cal_start && !cal_busy_q && !cal_done_q |=>
    vco_settle_wait_q && cal_busy_q) else $error("start did not open vco wait");
  a_vco_before_closed: assert property ($rose(closed_loop_wait_q) |->
    $past(vco_settle_wait_q) && !vco_settle_wait_q) else $error("closed wait out of order");
  a_vco_min_len: assert property ($rose(closed_loop_wait_q) |->
    $past(vco_settle_wait_q, 8)) else $error("vco wait too short");
  a_done_after_closed: assert property ($rose(cal_done_q) |->
    $past(closed_loop_wait_q) && !cal_busy_q) else $error("done without closed wait");
  a_done_one_cycle: assert property (cal_done_q |=> !cal_done_q)
    else $error("done longer than one cycle");
  a_busy_is_wait: assert property (cal_busy_q == (vco_settle_wait_q || closed_loop_wait_q))
    else $error("busy does not match waits");
  a_bw_write: assert property (reg_wr && reg_addr == PCWC_OFS_LOOP_BW |=>
    narrow_loop_bw_sel_q == $past(reg_wdata[0])) else $error("bandwidth select not written");
  a_rsvd_zero: assert property (reg_rd && reg_addr == PCWC_OFS_WAIT_TIMES |=>
    reg_rdata_q[7:4] == 4'h0) else $error("reserved bits not zero");
  c_cal_done: cover property (cal_done_q);
  c_narrow_bw: cover property ($rose(narrow_loop_bw_sel_q));
  c_eep_load: cover property (eep_load);
  c_start_refused: cover property (cal_start && cal_busy_q);
endmodule
bind pcwc_top pcwc_top_checker chk_inst (.*);

/* File: verif/testbench.sv */
// Self-checking testbench for the PLL calibration wait control
`timescale 1ns/100ps
module testbench;
  import pcwc_pkg::*;
  logic       clk_sys, arst_n, reg_wr, reg_rd, cal_start, eep_load;
  logic [7:0] reg_addr, reg_wdata, eep_wait_times, eep_loop_bw, reg_rdata_q;
  logic       cal_busy_q, vco_settle_wait_q, closed_loop_wait_q, cal_done_q;
  logic       narrow_loop_bw_sel_q;
  int         err_count, checks, n;
  int         nv[4] = '{PCWC_VCO0_US * PCWC_CLK_MHZ, 20, 40, 60};
  int         nc[4] = '{PCWC_CLW0_US * PCWC_CLK_MHZ, PCWC_CLW1_US * PCWC_CLK_MHZ, 44, 64};
  logic [7:0] rows[5][3] = '{'{8'h77, 8'hFF, 8'h0F}, '{8'h78, 8'hFF, 8'h01},
    '{8'h78, 8'h00, 8'h00}, '{8'h50, 8'hFF, 8'h00}, '{8'h77, 8'h09, 8'h09}};
  pcwc_top #(.VCO1_CYC(20), .VCO2_CYC(40), .VCO3_CYC(60),
    .CLW2_CYC(44), .CLW3_CYC(64)) pcwc_top_inst (.*);
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task finish_test;
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(reg_rdata_q, exp);
  endtask
  // Count one wait level, a repeat start is pulsed inside it
  task count_level(input logic which, input int exp);
    n = 0;
    while ((which ? closed_loop_wait_q : vco_settle_wait_q) === 1'b1 && n < 20000) begin
      n++;
      @(posedge clk_sys);
      cal_start <= (n == 3);
      #1;
    end
    checks++;
    if (n != exp) begin
      $display("wrong value at %0t: wait of %0d cycles, expected %0d", $time, n, exp);
      err_count++;
    end
    if (n >= 20000) begin
      err_count++;
      finish_test;
    end
  endtask
  task cal(input logic [1:0] v, input logic [1:0] c);
    wr(8'h77, {4'h0, c, v});
    @(posedge clk_sys);
    cal_start <= 1;
    @(posedge clk_sys);
    cal_start <= 0;
    #1 chk({7'h0, cal_busy_q}, 8'h01);
    count_level(0, nv[v] + 1);
    count_level(1, nc[c] + 1);
    chk({7'h0, cal_done_q}, 8'h01);
    @(posedge clk_sys);
    #1 chk({7'h0, cal_done_q}, 8'h00);
  endtask
  initial begin
    {arst_n, reg_wr, reg_rd, cal_start, eep_load} = '0;
    {reg_addr, reg_wdata, eep_wait_times, eep_loop_bw} = '0;
    err_count = 0;
    checks = 0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
      if (rows[i][0] == 8'h78) chk({7'h0, narrow_loop_bw_sel_q}, rows[i][2]);
    end
    wr(8'h78, 8'h01);
    // ----------------------------------------
    // Reset values, then EEPROM load
    // ----------------------------------------
    arst_n <= 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1;
    repeat (3) @(posedge clk_sys);
    rd(8'h77, 8'h01);
    rd(8'h78, 8'h00);
    @(posedge clk_sys);
    eep_wait_times <= 8'h0E;
    eep_loop_bw <= 8'h01;
    eep_load <= 1;
    @(posedge clk_sys);
    eep_load <= 0;
    rd(8'h77, 8'h0E);
    chk({7'h0, narrow_loop_bw_sel_q}, 8'h01);
    // Register write beats EEPROM load on the same register
    @(posedge clk_sys);
    eep_wait_times <= 8'h05;
    eep_loop_bw <= 8'h01;
    eep_load <= 1;
    reg_wr <= 1;
    reg_addr <= 8'h78;
    reg_wdata <= 8'h00;
    @(posedge clk_sys);
    eep_load <= 0;
    reg_wr <= 0;
    rd(8'h78, 8'h00);
    chk({7'h0, narrow_loop_bw_sel_q}, 8'h00);
    rd(8'h77, 8'h05);
    for (int k = 0; k < 4; k++) cal(2'(k), 2'(3 - k));
    finish_test;
  end
endmodule
